// File: rtl/fpkl_pkg.sv
/*
 Package for the front-panel button and keylock controller: register map,
 field positions, reset values, colour codes and timing counts.
 Assumes a 20 MHz system clock; all cycle counts derive from it.
*/
package fpkl_pkg;

   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned LONG_PRESS_S = 6;
   localparam int unsigned MUTE_MIN = 10;
   localparam int unsigned TEST_STEP_S = 1;
   localparam int unsigned DEBOUNCE_MS = 10;
   localparam int unsigned LONG_W = 27;
   localparam int unsigned MUTE_W = 34;
   localparam int unsigned SEC_W = 25;
   localparam int unsigned DB_W = 18;
   localparam logic [LONG_W-1:0] LONG_CYC = LONG_W'(LONG_PRESS_S * CLK_HZ);
   localparam longint unsigned MUTE_CYC_L =
      longint'(MUTE_MIN) * 64'd60 * longint'(CLK_HZ);
   localparam logic [MUTE_W-1:0] MUTE_CYC = MUTE_W'(MUTE_CYC_L);
   localparam logic [SEC_W-1:0] SEC_CYC = SEC_W'(TEST_STEP_S * CLK_HZ);
   localparam logic [DB_W-1:0] DB_CYC = DB_W'(DEBOUNCE_MS * (CLK_HZ / 1000));

   // ==========================================================
   // Inputs and indicator codes
   localparam int unsigned NLOCK = 4;
   localparam logic [1:0] COL_OFF = 2'h0;
   localparam logic [1:0] COL_RED = 2'h1;
   localparam logic [1:0] COL_GREEN = 2'h2;
   localparam logic [1:0] COL_BLUE = 2'h3;

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_IRQ_STAT = 4'h8;
   localparam logic [3:0] REG_IRQ_MASK = 4'hc;
   localparam int unsigned CTRL_PORTS_EN = 0;
   localparam int unsigned CTRL_PWRUP_INH = 1;
   localparam logic [1:0] CTRL_RST = 2'h3;
   localparam int unsigned ST_KEY_RUN = 0;
   localparam int unsigned ST_BTN = 1;
   localparam int unsigned ST_WARN = 2;
   localparam int unsigned ST_MUTE = 3;
   localparam int unsigned ST_PILOT_ALT = 4;
   localparam int unsigned ST_ROUTE_BLK = 5;
   localparam int unsigned ST_LOCK_LSB = 8;
   localparam int unsigned ST_STEP_LSB = 16;
   localparam int unsigned NIRQ = 4;
   localparam int unsigned IRQ_SHORT = 0;
   localparam int unsigned IRQ_LONG = 1;
   localparam int unsigned IRQ_REFUSED = 2;
   localparam int unsigned IRQ_LOCK = 3;
   localparam logic [NIRQ-1:0] IRQ_MASK_RST = 4'h0;

   // Press measurement states
   typedef enum logic [1:0] {
      PR_IDLE,
      PR_PRESS,
      PR_HELD
   } fpkl_press_t;

endpackage : fpkl_pkg

// File: rtl/fpkl_debounce.sv
/*
 Two-flop synchroniser followed by a stability debouncer for a group of
 pin inputs. The group output changes only after the synchronised value
 has held still for the debounce count. Assumes asynchronous pins.
*/
`timescale 1ns/100ps
module fpkl_debounce
   import fpkl_pkg::*;
#(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] P_RST = '0,
   parameter logic [DB_W-1:0] P_DB_CYC = DB_CYC
) (
   // Clock, reset, enable
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   // Raw pins and clean level
   input wire logic [WIDTH-1:0] i_pin,
   output logic [WIDTH-1:0] o_level
);

   logic [WIDTH-1:0] meta_ff, sync_ff, last_ff, level_ff;
   logic [WIDTH-1:0] nxt_last, nxt_level;
   logic [DB_W-1:0] cnt_ff, nxt_cnt;

   // ==========================================================
   // Debounce: restart count on any change of the synced value
   always_comb begin
      nxt_last = sync_ff;
      nxt_level = level_ff;
      nxt_cnt = cnt_ff;
      if (sync_ff != last_ff) begin
         nxt_cnt = '0;
      end else if (cnt_ff >= P_DB_CYC - 1'b1) begin
         nxt_level = last_ff;
      end else begin
         nxt_cnt = cnt_ff + 1'b1;
      end
   end

   // Only the second flop reads the first
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         meta_ff <= P_RST;
         sync_ff <= P_RST;
         last_ff <= P_RST;
         level_ff <= P_RST;
         cnt_ff <= '0;
      end else if (i_ce) begin
         meta_ff <= i_pin;
         sync_ff <= meta_ff;
         last_ff <= nxt_last;
         level_ff <= nxt_level;
         cnt_ff <= nxt_cnt;
      end
   end

   assign o_level = level_ff;

endmodule : fpkl_debounce

// File: rtl/fpkl_ctrl.sv
/*
 Front-panel pushbutton and keylock controller: press timing, alarm mute,
 indicator self-tests, power requests, routing lock and module lock
 warnings, with an Avalon-MM register slave and one level interrupt.
 Assumes button, key and lock contacts are raw pins; all other inputs
 are synchronous to i_sys_clk.
*/
// Contract
// - Short press while sounding mutes alarm ten minutes
// - Mute leaves alarm relay output unchanged
// - Short press runs dashboard red-green-blue test
// - Short press runs pilot red-green test
// - Short press clears alternating pilot status
// - Run key long hold requests power toggle
// - Locked key long hold starts no sequence
// - Key decoded as run or locked only
// - Touch console plus locked key blocks routing
// - Key never affects serial and USB ports
// - Unsecured module raises warning, may inhibit power-up
// - Alternating pilot marks unattended auto restart
`timescale 1ns/100ps
module fpkl_ctrl
   import fpkl_pkg::*;
#(
   parameter logic [LONG_W-1:0] P_LONG_CYC = LONG_CYC,
   parameter logic [MUTE_W-1:0] P_MUTE_CYC = MUTE_CYC,
   parameter logic [SEC_W-1:0] P_SEC_CYC = SEC_CYC,
   parameter logic [DB_W-1:0] P_DB_CYC = DB_CYC
) (
   // Clock, reset, enable
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   // Front-panel pins
   input wire logic i_btn,
   input wire logic i_key_run,
   input wire logic [NLOCK-1:0] i_lock_secure,
   // System state
   input wire logic i_alarm_sounding,
   input wire logic i_alarm_relay,
   input wire logic i_sys_on,
   input wire logic i_auto_restart,
   input wire logic i_touch_console_option,
   // Actions
   output logic o_audible_alarm,
   output logic o_alarm_mute,
   output logic o_alarm_relay,
   output logic [1:0] o_dash_color,
   output logic [1:0] o_pilot_color,
   output logic o_pilot_alt,
   output logic o_pwr_up_req,
   output logic o_pwr_down_req,
   output logic o_route_block,
   output logic o_ports_en,
   output logic o_sys_warn,
   output logic o_pwrup_inhibit,
   // Avalon-MM slave
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Interrupt
   output logic o_irq
);

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);

   // ==========================================================
   // Clean inputs
   logic btn_db, key_db;
   logic [NLOCK-1:0] lock_db;

   fpkl_debounce #(.WIDTH(1), .P_RST(1'b0), .P_DB_CYC(P_DB_CYC)) u_btn (
      .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_ce(i_ce),
      .i_pin(i_btn), .o_level(btn_db));
   // key is one bit: run or locked
   fpkl_debounce #(.WIDTH(1), .P_RST(1'b0), .P_DB_CYC(P_DB_CYC)) u_key (
      .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_ce(i_ce),
      .i_pin(i_key_run), .o_level(key_db));
   fpkl_debounce #(.WIDTH(NLOCK), .P_RST('1), .P_DB_CYC(P_DB_CYC)) u_lock (
      .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_ce(i_ce),
      .i_pin(i_lock_secure), .o_level(lock_db));

   // ==========================================================
   // Press timing
   fpkl_press_t st_ff, nxt_st;
   logic [LONG_W-1:0] hold_ff, nxt_hold;
   logic short_ev, long_ev;

   // Short event only from PRESS, so a long hold never ends short
   always_comb begin
      nxt_st = st_ff;
      nxt_hold = hold_ff;
      short_ev = 1'b0;
      long_ev = 1'b0;
      unique case (st_ff)
         PR_IDLE: begin
            nxt_hold = '0;
            if (btn_db) begin
               nxt_st = PR_PRESS;
            end
         end
         PR_PRESS: begin
            if (!btn_db) begin
               short_ev = 1'b1;
               nxt_st = PR_IDLE;
            end else if (hold_ff >= P_LONG_CYC - 1'b1) begin
               long_ev = 1'b1;
               nxt_st = PR_HELD;
            end else begin
               nxt_hold = hold_ff + 1'b1;
            end
         end
         PR_HELD: begin
            if (!btn_db) begin
               nxt_st = PR_IDLE;
            end
         end
         // Unused code of the 2-bit state falls back to idle
         default: begin
            nxt_st = PR_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         st_ff <= PR_IDLE;
         hold_ff <= '0;
      end else if (i_ce) begin
         st_ff <= nxt_st;
         hold_ff <= nxt_hold;
      end
   end

   // ==========================================================
   // Actions: mute, tests, pilot status, power, routing
   logic [MUTE_W-1:0] mute_ff, nxt_mute;
   logic [SEC_W-1:0] sec_ff, nxt_sec;
   logic [1:0] step_ff, nxt_step;
   logic alt_ff, nxt_alt;
   logic up_ff, nxt_up, down_ff, nxt_down;
   logic refused, warn;
   logic [1:0] ctrl_ff;

   assign warn = ~&lock_db;

   always_comb begin
      nxt_mute = mute_ff;
      nxt_sec = sec_ff;
      nxt_step = step_ff;
      nxt_alt = alt_ff;
      nxt_up = 1'b0;
      nxt_down = 1'b0;
      refused = 1'b0;
      // Mute timer runs down regardless of key
      if (mute_ff != '0) begin
         nxt_mute = mute_ff - 1'b1;
      end
      // Step the self-test once per second
      if (step_ff != 2'h0) begin
         if (sec_ff == '0) begin
            nxt_step = step_ff + 2'h1;
            nxt_sec = P_SEC_CYC - 1'b1;
         end else begin
            nxt_sec = sec_ff - 1'b1;
         end
      end
      if (i_auto_restart && i_sys_on) begin
         nxt_alt = 1'b1;
      end
      if (short_ev) begin
         if (i_alarm_sounding) begin
            nxt_mute = P_MUTE_CYC;
         end
         nxt_step = 2'h1;
         nxt_sec = P_SEC_CYC - 1'b1;
         nxt_alt = 1'b0;
      end
      // long hold acts only with key in run
      if (long_ev) begin
         if (!key_db) begin
            refused = 1'b1;
         end else if (i_sys_on) begin
            nxt_down = 1'b1;
         end else if (warn && ctrl_ff[CTRL_PWRUP_INH]) begin
            refused = 1'b1;
         end else begin
            nxt_up = 1'b1;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         mute_ff <= '0;
         sec_ff <= '0;
         step_ff <= 2'h0;
         alt_ff <= 1'b0;
         up_ff <= 1'b0;
         down_ff <= 1'b0;
      end else if (i_ce) begin
         mute_ff <= nxt_mute;
         sec_ff <= nxt_sec;
         step_ff <= nxt_step;
         alt_ff <= nxt_alt;
         up_ff <= nxt_up;
         down_ff <= nxt_down;
      end
   end

   // ==========================================================
   // Output flops; colours decoded ahead so outputs stay registered
   logic [1:0] nxt_dash, nxt_pilot;
   always_comb begin
      nxt_dash = nxt_step;
      nxt_pilot = (nxt_step == 2'h3) ? COL_OFF : nxt_step;
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         o_audible_alarm <= 1'b0;
         o_alarm_mute <= 1'b0;
         o_alarm_relay <= 1'b0;
         o_dash_color <= COL_OFF;
         o_pilot_color <= COL_OFF;
         o_pilot_alt <= 1'b0;
         o_route_block <= 1'b0;
         o_ports_en <= 1'b0;
         o_sys_warn <= 1'b0;
         o_pwrup_inhibit <= 1'b0;
      end else if (i_ce) begin
         o_audible_alarm <= i_alarm_sounding && (nxt_mute == '0);
         o_alarm_mute <= nxt_mute != '0;
         // relay follows the alarm, never the mute
         o_alarm_relay <= i_alarm_relay;
         o_dash_color <= nxt_dash;
         o_pilot_color <= nxt_pilot;
         o_pilot_alt <= nxt_alt;
         // locked key blocks touch console routing
         o_route_block <= i_touch_console_option && !key_db;
         // port enable from software only, key not used
         o_ports_en <= ctrl_ff[CTRL_PORTS_EN];
         o_sys_warn <= warn;
         o_pwrup_inhibit <= warn && ctrl_ff[CTRL_PWRUP_INH];
      end
   end

   assign o_pwr_up_req = up_ff;
   assign o_pwr_down_req = down_ff;

   // ==========================================================
   // Avalon-MM slave: one wait state, then the taking edge
   logic wait_ff, nxt_wait;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [NIRQ-1:0] irq_st_ff, nxt_irq_st, irq_mask_ff, nxt_irq_mask, ev;
   logic [1:0] nxt_ctrl;
   logic irq_ff, nxt_irq, warn_q_ff, req, take;

   assign req = i_avs_read || i_avs_write;
   assign take = req && !wait_ff;

   always_comb begin
      ev = '0;
      ev[IRQ_SHORT] = short_ev;
      ev[IRQ_LONG] = nxt_up || nxt_down;
      ev[IRQ_REFUSED] = refused;
      ev[IRQ_LOCK] = warn && !warn_q_ff;
      nxt_wait = !(req && wait_ff);
      nxt_rdata = rdata_ff;
      nxt_ctrl = ctrl_ff;
      nxt_irq_mask = irq_mask_ff;
      nxt_irq_st = irq_st_ff;
      // Read data loaded during the wait cycle, held for the take edge
      if (req && wait_ff) begin
         nxt_rdata = '0;
         unique case (i_avs_address)
            REG_CTRL: nxt_rdata[1:0] = ctrl_ff;
            REG_STATUS: begin
               nxt_rdata[ST_KEY_RUN] = key_db;
               nxt_rdata[ST_BTN] = btn_db;
               nxt_rdata[ST_WARN] = warn;
               nxt_rdata[ST_MUTE] = mute_ff != '0;
               nxt_rdata[ST_PILOT_ALT] = alt_ff;
               nxt_rdata[ST_ROUTE_BLK] = o_route_block;
               nxt_rdata[ST_LOCK_LSB +: NLOCK] = lock_db;
               nxt_rdata[ST_STEP_LSB +: 2] = step_ff;
            end
            REG_IRQ_STAT: nxt_rdata[NIRQ-1:0] = irq_st_ff;
            REG_IRQ_MASK: nxt_rdata[NIRQ-1:0] = irq_mask_ff;
            default: nxt_rdata = '0;
         endcase
      end
      if (take && i_avs_write && i_avs_byteenable[0]) begin
         if (i_avs_address == REG_CTRL) begin
            nxt_ctrl = i_avs_writedata[1:0];
         end
         if (i_avs_address == REG_IRQ_MASK) begin
            nxt_irq_mask = i_avs_writedata[NIRQ-1:0];
         end
      end
      // Read clears; a same-cycle event still sets
      if (take && i_avs_read && i_avs_address == REG_IRQ_STAT) begin
         nxt_irq_st = '0;
      end
      nxt_irq_st = nxt_irq_st | ev;
      nxt_irq = |(nxt_irq_st & nxt_irq_mask);
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         wait_ff <= 1'b1;
         rdata_ff <= '0;
         ctrl_ff <= CTRL_RST;
         irq_mask_ff <= IRQ_MASK_RST;
         irq_st_ff <= '0;
         irq_ff <= 1'b0;
         warn_q_ff <= 1'b0;
      end else if (i_ce) begin
         wait_ff <= nxt_wait;
         rdata_ff <= nxt_rdata;
         ctrl_ff <= nxt_ctrl;
         irq_mask_ff <= nxt_irq_mask;
         irq_st_ff <= nxt_irq_st;
         irq_ff <= nxt_irq;
         warn_q_ff <= warn;
      end
   end

   assign o_avs_readdata = rdata_ff;
   assign o_avs_waitrequest = wait_ff;
   assign o_irq = irq_ff;

   // ==========================================================
   // Checks
   sequence s_test_start;
      i_ce && short_ev;
   endsequence
   sequence s_step_end(int unsigned s);
      i_ce && step_ff == 2'(s) && sec_ff == '0;
   endsequence

   short_mute_a: assert property (
      s_test_start ##0 i_alarm_sounding |=> o_alarm_mute && !o_audible_alarm
         && mute_ff == P_MUTE_CYC)
      else $error("short press did not load mute");
   relay_pass_a: assert property (
      i_ce |=> o_alarm_relay == $past(i_alarm_relay))
      else $error("alarm relay disturbed");
   dash_seq_a: assert property (
      s_test_start |=> o_dash_color == COL_RED && o_pilot_color == COL_RED)
      else $error("dashboard test not red first");
   dash_blue_a: assert property (
      s_step_end(2) ##0 !short_ev |=> o_dash_color == COL_BLUE)
      else $error("dashboard test skipped blue");
   pilot_seq_a: assert property (
      s_step_end(1) ##0 !short_ev |=> o_pilot_color == COL_GREEN
         && o_dash_color == COL_GREEN)
      else $error("pilot test not green second");
   pilot_clear_a: assert property (
      s_test_start |=> !o_pilot_alt)
      else $error("pilot alternation not cleared");
   pwr_down_a: assert property (
      i_ce && long_ev && key_db && i_sys_on |=> o_pwr_down_req
         ##1 !o_pwr_down_req || !$past(i_ce))
      else $error("power down not requested");
   locked_nopwr_a: assert property (
      i_ce && long_ev && !key_db |=> !o_pwr_up_req && !o_pwr_down_req)
      else $error("locked key started power sequence");
   route_blk_a: assert property (
      i_ce && i_touch_console_option && !key_db |=> o_route_block)
      else $error("routing not blocked");
   ports_key_a: assert property (
      i_ce |=> o_ports_en == $past(ctrl_ff[CTRL_PORTS_EN]))
      else $error("port enable not from control");
   lock_warn_a: assert property (
      i_ce && !(&lock_db) |=> o_sys_warn)
      else $error("open lock gave no warning");
   alt_set_a: assert property (
      i_ce && i_auto_restart && i_sys_on && !short_ev |=> o_pilot_alt)
      else $error("auto restart not shown");
   held_noshort_a: assert property (
      st_ff == PR_HELD |-> !short_ev)
      else $error("long hold gave short action");

endmodule : fpkl_ctrl

// File: verif/fpkl_operator.sv
/*
 Operator model: a bouncing pushbutton and a two-position key switch.
 Assumes the bench calls its tasks from one process at a time.
*/
`timescale 1ns/100ps
module fpkl_operator (
   // Clock
   input wire logic i_sys_clk,
   // Panel contacts
   output logic o_btn,
   output logic o_key_run
);
   // Button released, key in run at power-up
   initial begin
      o_btn = 1'h0;
      o_key_run = 1'h1;
   end

   // ==========================================================
   // Press with a bounce at each end; real contacts chatter
   task automatic press(input int n);
      int i;
      @(posedge i_sys_clk) o_btn <= 1'h1;
      @(posedge i_sys_clk) o_btn <= 1'h0;
      for (i = 0; i < n; i++) begin
         @(posedge i_sys_clk) o_btn <= 1'h1;
      end
      @(posedge i_sys_clk) o_btn <= 1'h0;
      @(posedge i_sys_clk) o_btn <= 1'h1;
      @(posedge i_sys_clk) o_btn <= 1'h0;
   endtask : press

   // Key turn, clean edge
   task automatic turn_key(input logic run);
      @(posedge i_sys_clk) o_key_run <= run;
   endtask : turn_key
endmodule : fpkl_operator

// File: verif/tb_front_panel_button_keylock_ctrl.sv
/*
 Testbench for the front-panel controller: drives panel and bus, notes
 expected results in a queue, a monitor compares them as they appear.
 Assumes short counts set through the design parameters.
*/
`timescale 1ns/100ps
module tb_front_panel_button_keylock_ctrl
   import fpkl_pkg::*;
;
   localparam int LG = 40;
   localparam int MU = 200;
   localparam int SE = 10;
   logic i_sys_clk = 1'h0;
   logic i_nrst = 1'h0;
   logic i_btn, i_key_run;
   logic [NLOCK-1:0] i_lock_secure = 4'hf;
   logic i_alarm_sounding = 1'h0, i_alarm_relay = 1'h0, i_sys_on = 1'h0;
   logic i_auto_restart = 1'h0, i_touch_console_option = 1'h0;
   logic [3:0] i_avs_address = 4'h0, i_avs_byteenable = 4'h0;
   logic i_avs_read = 1'h0, i_avs_write = 1'h0;
   logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata;
   logic o_audible_alarm, o_alarm_mute, o_alarm_relay, o_pilot_alt;
   logic [1:0] o_dash_color, o_pilot_color;
   logic o_pwr_up_req, o_pwr_down_req, o_route_block, o_ports_en;
   logic o_sys_warn, o_pwrup_inhibit, o_avs_waitrequest, o_irq;
   int fail_count = 0;
   int comparisons = 0;
   int seed = 37078;
   int k;
   logic [39:0] q[$];
   logic [3:0] pc = 4'h0, cur, lk;
   logic [15:0] cd = 16'h0, md = 16'h0;
   logic rl = 1'h0;

   // ==========================================================
   // Clock, device and operator
   always #25 i_sys_clk = ~i_sys_clk;

   fpkl_ctrl #(.P_LONG_CYC(LONG_W'(LG)), .P_MUTE_CYC(MUTE_W'(MU)),
      .P_SEC_CYC(SEC_W'(SE)), .P_DB_CYC(DB_W'(3))) u_dut (
      .i_sys_clk, .i_nrst, .i_ce(1'h1), .i_btn, .i_key_run,
      .i_lock_secure, .i_alarm_sounding, .i_alarm_relay, .i_sys_on,
      .i_auto_restart, .i_touch_console_option, .o_audible_alarm,
      .o_alarm_mute, .o_alarm_relay, .o_dash_color, .o_pilot_color,
      .o_pilot_alt, .o_pwr_up_req, .o_pwr_down_req, .o_route_block,
      .o_ports_en, .o_sys_warn, .o_pwrup_inhibit, .i_avs_address,
      .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
      .o_avs_readdata, .o_avs_waitrequest, .o_irq);

   fpkl_operator u_op (.i_sys_clk, .o_btn(i_btn), .o_key_run(i_key_run));

   // ==========================================================
   // Compare, verdict, limits
   task automatic chk(input logic [39:0] s, input logic [39:0] e);
      comparisons++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk

   task automatic results();
      $display("Counts: %0d compared, %0d failed", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results

   task automatic hang();
      fail_count++;
      $display("[ERR] %0t wait limit reached", $time);
      results();
   endtask : hang

   // Unexpected results meet an empty queue and always mismatch
   task automatic obs(input logic [39:0] s);
      chk(s, (q.size() > 0) ? q.pop_front() : ~s);
   endtask : obs

   task automatic tick(input int n);
      repeat (n) @(negedge i_sys_clk);
   endtask : tick

   task automatic drain();
      int n;
      for (n = 0; n < 600 && q.size() > 0; n++) @(negedge i_sys_clk);
      if (q.size() > 0) hang();
   endtask : drain

   // ==========================================================
   // Avalon master: hold the request until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d, input logic [3:0] be);
      int n;
      @(posedge i_sys_clk);
      i_avs_read <= ~w;
      i_avs_write <= w;
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_byteenable <= be;
      n = 0;
      do begin
         @(negedge i_sys_clk);
         n++;
      end while (o_avs_waitrequest && n < 50);
      if (o_avs_waitrequest) hang();
      @(posedge i_sys_clk);
      i_avs_read <= 1'h0;
      i_avs_write <= 1'h0;
   endtask : bus

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      q.push_back({8'h1, e});
      bus(1'h0, a, 32'h0, 4'hf);
   endtask : rd

   task automatic short_press(input logic snd);
      q.push_back({8'h3, 16'h0, 12'h0, COL_RED, COL_RED});
      q.push_back({8'h3, 16'(SE), 12'h0, COL_GREEN, COL_GREEN});
      q.push_back({8'h3, 16'(SE), 12'h0, COL_BLUE, COL_OFF});
      q.push_back({8'h3, 16'(SE), 16'h0});
      if (snd) q.push_back({8'h4, 16'h0, 16'(MU)});
      u_op.press(10 + $unsigned($random(seed)) % 20);
      drain();
   endtask : short_press

   // ==========================================================
   // Monitor, settled values at the falling edge
   always @(negedge i_sys_clk) begin
      cur = {o_dash_color, o_pilot_color};
      if (i_avs_read && !o_avs_waitrequest) obs({8'h1, o_avs_readdata});
      if (o_pwr_up_req || o_pwr_down_req) begin
         obs({8'h2, 30'h0, o_pwr_up_req, o_pwr_down_req});
      end
      if (cur != pc) begin
         obs({8'h3, (pc == 4'h0) ? 16'h0 : cd, 12'h0, cur});
         cd = 16'h1;
      end else begin
         cd++;
      end
      pc = cur;
      if (o_alarm_mute) begin
         md++;
         chk(o_audible_alarm, 1'h0);
      end else if (md != 16'h0) begin
         obs({8'h4, 16'h0, md});
         md = 16'h0;
      end
      if (i_nrst) chk(o_alarm_relay, rl);
      rl = i_alarm_relay;
   end

   // Random relay requests keep moving through every test
   always @(posedge i_sys_clk) begin
      if (i_nrst) i_alarm_relay <= 1'($random(seed));
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (10) @(posedge i_sys_clk);
      i_nrst <= 1'h1;
      rd(REG_CTRL, 32'h3);
      rd(REG_IRQ_MASK, 32'h0);
      bus(1'h1, REG_IRQ_MASK, 32'hf, 4'h0);
      rd(REG_IRQ_MASK, 32'h0);
      rd(4'h3, 32'h0);
      bus(1'h1, REG_IRQ_MASK, 32'h1, 4'h1);
      $display("Test registers done");
      i_sys_on <= 1'h1;
      i_alarm_sounding <= 1'h1;
      for (k = 0; k < 2; k++) begin
         u_op.turn_key(k[0]);
         @(posedge i_sys_clk);
         i_auto_restart <= 1'h1;
         @(posedge i_sys_clk);
         i_auto_restart <= 1'h0;
         tick(8);
         chk(o_pilot_alt, 1'h1);
         short_press(1'h1);
         chk(o_pilot_alt, 1'h0);
         chk(o_irq, 1'h1);
         rd(REG_IRQ_STAT, 32'h1);
         tick(3);
         chk(o_irq, 1'h0);
      end
      $display("Test short press done");
      u_op.turn_key(1'h1);
      tick(8);
      // long hold toggles power, no test
      for (k = 0; k < 2; k++) begin
         @(posedge i_sys_clk);
         i_sys_on <= k[0];
         q.push_back({8'h2, 30'h0, ~k[0], k[0]});
         u_op.press(LG + 20);
         tick(SE * 5);
         drain();
      end
      rd(REG_IRQ_STAT, 32'h2);
      u_op.turn_key(1'h0);
      tick(8);
      u_op.press(LG + 20);
      tick(SE * 5);
      rd(REG_IRQ_STAT, 32'h4);
      $display("Test long hold done");
      bus(1'h1, REG_CTRL, 32'h3, 4'hf);
      for (k = 0; k < 4; k++) begin
         @(posedge i_sys_clk);
         i_touch_console_option <= k[1];
         u_op.turn_key(k[0]);
         tick(8);
         chk(o_route_block, k[1] & ~k[0]);
         chk(o_ports_en, 1'h1);
         rd(REG_STATUS, 32'hf00 | k[0] | ((k[1] & ~k[0]) << 5));
      end
      $display("Test key modes done");
      lk = 4'($random(seed));
      lk[$unsigned($random(seed)) % 4] = 1'h0;
      @(posedge i_sys_clk);
      i_lock_secure <= lk;
      i_sys_on <= 1'h0;
      u_op.turn_key(1'h1);
      tick(8);
      chk(o_sys_warn, 1'h1);
      chk(o_pwrup_inhibit, 1'h1);
      u_op.press(LG + 20);
      tick(SE * 5);
      rd(REG_IRQ_STAT, 32'hc);
      @(posedge i_sys_clk);
      i_lock_secure <= 4'hf;
      tick(8);
      chk(o_sys_warn, 1'h0);
      $display("Test lock warning done");
      results();
   end
endmodule : tb_front_panel_button_keylock_ctrl
